// ---- common/iafl_pkg.sv ----
// Register map, field positions and reset values of the abort and FIFO level status block
package iafl_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;
  localparam int unsigned LEVEL_W = 6;
  localparam int unsigned HOLD_W = 16;
  localparam int unsigned CAUSE_W = 16;
  localparam int unsigned SYNC_W = 2;

  localparam logic [ADDR_W-1:0] TX_LEVEL_ADDR = 32'h5000_1474;
  localparam logic [ADDR_W-1:0] RX_LEVEL_ADDR = 32'h5000_1478;
  localparam logic [ADDR_W-1:0] HOLD_ADDR = 32'h5000_147C;
  localparam logic [ADDR_W-1:0] CAUSE_ADDR = 32'h5000_1480;

  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 6'h00;
  localparam logic [HOLD_W-1:0] HOLD_RESET = 16'h0001;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 2'h0;

  // Abort cause bit positions
  localparam int unsigned CB_SHORT_ADDRESS_UNACKED = 0;
  localparam int unsigned CB_LONG_ADDRESS_FIRST_UNACKED = 1;
  localparam int unsigned CB_LONG_ADDRESS_SECOND_UNACKED = 2;
  localparam int unsigned CB_DATA_BYTE_UNACKED = 3;
  localparam int unsigned CB_GENERAL_CALL_UNACKED = 4;
  localparam int unsigned CB_GENERAL_CALL_READ_MISUSE = 5;
  localparam int unsigned CB_START_BYTE_ACKED = 7;
  localparam int unsigned CB_HIGHSPEED_WITHOUT_RESTART = 8;
  localparam int unsigned CB_START_BYTE_WITHOUT_RESTART = 9;
  localparam int unsigned CB_TENBIT_READ_WITHOUT_RESTART = 10;
  localparam int unsigned CB_MASTER_DISABLED_ATTEMPT = 11;
  localparam int unsigned CB_ARBITRATION_LOST_FLAG = 12;
  localparam int unsigned CB_SLAVE_STALE_TX_FLUSH = 13;
  localparam int unsigned CB_SLAVE_TX_BUS_LOST = 14;
  localparam int unsigned CB_SLAVE_READ_CMD_CONFLICT = 15;

  // Bits whose clear beats a set arriving in the same cycle
  localparam logic [CAUSE_W-1:0] CAUSE_CLEAR_WINS = 16'h0200;

  typedef enum logic {BUS_IDLE, BUS_ANSWER} iafl_bus_e;
endpackage : iafl_pkg

// ---- design/iafl_abort_cause.sv ----
// Sticky abort cause flags with a common clear
`timescale 1ns/1ns
`default_nettype none
module iafl_abort_cause #(
  parameter int unsigned WIDTH = iafl_pkg::CAUSE_W,
  parameter logic [WIDTH-1:0] CLEAR_WINS = iafl_pkg::CAUSE_CLEAR_WINS
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic ce,
  input wire logic [WIDTH-1:0] setVec,
  input wire logic clear,
  output logic [WIDTH-1:0] cause
);
  import iafl_pkg::*;

  logic [WIDTH-1:0] cause_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          cause_q[i] <= 1'b0;
        end else if (ce) begin
          // Set beats clear, except where the clear is allowed to win
          if (setVec[i] && !(clear && CLEAR_WINS[i])) begin
            cause_q[i] <= 1'b1;
          end else if (clear) begin
            cause_q[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign cause = cause_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstN);

  set_sticks_a: assert property ((ce && !clear && (setVec != '0)) |=> ((cause & $past(setVec)) == $past(setVec)))
    else $error("abort cause bit not set by its event");
  hold_noclear_a: assert property ((ce && !clear) |=> ((cause & $past(cause)) == $past(cause)))
    else $error("abort cause bit dropped without clear");
endmodule : iafl_abort_cause
`default_nettype wire

// ---- design/iafl_status_regs.sv ----
// Abort cause, FIFO level and data hold register block with Avalon-MM slave
//
// Contract
// - Report transmit FIFO entry count in a 6-bit read-only field.
// - Report receive FIFO entry count in a 6-bit read-only field.
// - Data hold time register, 16 bits read-write, resets to one.
// - Bit 15 when software queues a read while serving a remote read.
// - Slave bus loss sets bit 14 and bit 12 together.
// - Transmitter compares data line on clock rise; mismatch means bus lost.
// - Slave read command with TX data pending sets bit 13 and abort interrupt.
// - Bit 12 on master arbitration loss; with bit 14 it means slave.
// - Master and slave roles may run at the same time.
// - Bit 11 when a master transfer starts with master mode disabled.
// - Bit 10 on 10-bit master read with restart disabled.
// - Bit 9 on START byte attempt with restart disabled.
// - Bit 8 on high-speed master transfer with restart disabled.
// - Bit 7 when a sent START byte is acknowledged.
// - Bit 3 when a data byte after an acked address is not acked.
// - Bit 0 when a 7-bit address is not acknowledged.
// - 10-bit mode: bit 1 first address byte unacked, bit 2 second.
// - Bit 4 general call unacked; bit 5 read queued after general call.
`timescale 1ns/1ns
`default_nettype none
module iafl_status_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [iafl_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [iafl_pkg::DATA_W-1:0] writedata,
  input wire logic [iafl_pkg::BE_W-1:0] byteenable,
  output logic [iafl_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  // FIFO levels from the controller
  input wire logic [iafl_pkg::LEVEL_W-1:0] txLevelCount,
  input wire logic [iafl_pkg::LEVEL_W-1:0] rxLevelCount,
  // Transmit FIFO push from software
  input wire logic txPush,
  input wire logic txPushIsRead,
  // Slave side status
  input wire logic slvReadReqActive,
  input wire logic slvReadCmd,
  input wire logic slvTxActive,
  // Master side status
  input wire logic mstTxActive,
  input wire logic mstStartReq,
  input wire logic mstPending,
  input wire logic masterEnable,
  input wire logic repeatedStartAllow,
  input wire logic tenBitMode,
  input wire logic highSpeedMode,
  input wire logic targetSpecial,
  input wire logic gencallOrStartbyteSelect,
  input wire logic mstReadCmd,
  input wire logic gencallActive,
  input wire logic addrUnacked,
  input wire logic addrSecondByte,
  input wire logic dataByteUnacked,
  input wire logic startByteAcked,
  // Two-wire bus pins and driven data bit
  input wire logic sdaIn,
  input wire logic sclIn,
  input wire logic sdaDriveBit,
  // Abort clear from the clear register
  input wire logic abortClear,
  output logic [iafl_pkg::HOLD_W-1:0] dataHoldCycles,
  output logic [iafl_pkg::CAUSE_W-1:0] transmitAbortCause,
  output logic transmitAbortIrq
);
  import iafl_pkg::*;

  logic [SYNC_W-1:0] rstSync_q;
  logic rstN;
  logic [SYNC_W-1:0] sdaSync_q;
  logic [SYNC_W-1:0] sclSync_q;
  logic sclPrev_q;
  logic sclRise;
  logic txActive;
  logic busLost;
  logic slvTxLost;
  logic mstLost;
  logic sbyteCond;
  logic [CAUSE_W-1:0] setVec;
  logic [CAUSE_W-1:0] abortCause;
  logic [HOLD_W-1:0] hold_q;
  logic [DATA_W-1:0] readdata_q;
  logic irq_q;
  iafl_bus_e busState_q;
  logic busReq;
  logic rdLoad;
  logic wrTake;

  function automatic logic [DATA_W-1:0] regRead(
    input logic [ADDR_W-1:0] addr,
    input logic [LEVEL_W-1:0] txl,
    input logic [LEVEL_W-1:0] rxl,
    input logic [HOLD_W-1:0] hold,
    input logic [CAUSE_W-1:0] cause
  );
    logic [DATA_W-1:0] val;
    val = READ_ZERO;
    case (addr)
      TX_LEVEL_ADDR: val[LEVEL_W-1:0] = txl;
      RX_LEVEL_ADDR: val[LEVEL_W-1:0] = rxl;
      HOLD_ADDR: val[HOLD_W-1:0] = hold;
      CAUSE_ADDR: val[CAUSE_W-1:0] = cause;
      default: val = READ_ZERO;
    endcase
    return val;
  endfunction : regRead

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= SYNC_RESET;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstN = rstSync_q[SYNC_W-1];

  // Pin synchronisers; only the second stage is looked at
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sdaSync_q <= {SYNC_W{1'b1}};
      sclSync_q <= {SYNC_W{1'b1}};
      sclPrev_q <= 1'b1;
    end else if (ce) begin
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclSync_q <= {sclSync_q[0], sclIn};
      sclPrev_q <= sclSync_q[SYNC_W-1];
    end
  end

  assign sclRise = sclSync_q[SYNC_W-1] && !sclPrev_q;
  // Either role may transmit, and both may be busy at once
  assign txActive = mstTxActive || slvTxActive;
  assign busLost = sclRise && txActive && (sdaSync_q[SYNC_W-1] != sdaDriveBit);
  assign slvTxLost = busLost && slvTxActive;
  assign mstLost = busLost && mstTxActive;
  // Level cause, so a clear with the cause still present re-arms it
  assign sbyteCond = mstPending && targetSpecial && gencallOrStartbyteSelect && !repeatedStartAllow;

  always_comb begin
    setVec = CAUSE_RESET;
    setVec[CB_SLAVE_READ_CMD_CONFLICT] = slvReadReqActive && txPush && txPushIsRead;
    setVec[CB_SLAVE_TX_BUS_LOST] = slvTxLost;
    setVec[CB_SLAVE_STALE_TX_FLUSH] = slvReadCmd && (txLevelCount != LEVEL_RESET);
    setVec[CB_ARBITRATION_LOST_FLAG] = slvTxLost || mstLost;
    setVec[CB_MASTER_DISABLED_ATTEMPT] = mstStartReq && !masterEnable;
    setVec[CB_TENBIT_READ_WITHOUT_RESTART] = mstReadCmd && tenBitMode && !repeatedStartAllow;
    setVec[CB_START_BYTE_WITHOUT_RESTART] = sbyteCond;
    setVec[CB_HIGHSPEED_WITHOUT_RESTART] = mstStartReq && highSpeedMode && !repeatedStartAllow;
    setVec[CB_START_BYTE_ACKED] = startByteAcked;
    setVec[CB_GENERAL_CALL_READ_MISUSE] = gencallActive && txPush && txPushIsRead;
    setVec[CB_GENERAL_CALL_UNACKED] = addrUnacked && gencallActive;
    setVec[CB_DATA_BYTE_UNACKED] = dataByteUnacked;
    setVec[CB_LONG_ADDRESS_SECOND_UNACKED] = addrUnacked && !gencallActive && tenBitMode && addrSecondByte;
    setVec[CB_LONG_ADDRESS_FIRST_UNACKED] = addrUnacked && !gencallActive && tenBitMode && !addrSecondByte;
    setVec[CB_SHORT_ADDRESS_UNACKED] = addrUnacked && !gencallActive && !tenBitMode;
  end

  iafl_abort_cause #(
    .WIDTH(CAUSE_W),
    .CLEAR_WINS(CAUSE_CLEAR_WINS)
  ) u_cause (
    .clk(clk),
    .rstN(rstN),
    .ce(ce),
    .setVec(setVec),
    .clear(abortClear),
    .cause(abortCause)
  );

  // Abort interrupt level follows any pending cause so TX data gets flushed
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= |(abortCause | setVec);
    end
  end

  // Bus handshake: one wait cycle, read data captured before release
  assign busReq = read || write;
  assign rdLoad = read && (busState_q == BUS_IDLE);
  assign wrTake = write && (busState_q == BUS_ANSWER) && ce;
  assign waitrequest = busReq && !(busState_q == BUS_ANSWER && ce);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      busState_q <= BUS_IDLE;
    end else if (ce) begin
      case (busState_q)
        BUS_IDLE: begin
          if (busReq) begin
            busState_q <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: begin
          busState_q <= BUS_IDLE;
        end
        default: begin
          busState_q <= BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      readdata_q <= READ_ZERO;
    end else if (ce && rdLoad) begin
      readdata_q <= regRead(address, txLevelCount, rxLevelCount, hold_q, abortCause);
    end
  end

  // Only the hold register is writable; other writes are dropped
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      hold_q <= HOLD_RESET;
    end else if (wrTake && address == HOLD_ADDR) begin
      if (byteenable[0]) begin
        hold_q[7:0] <= writedata[7:0];
      end
      if (byteenable[1]) begin
        hold_q[15:8] <= writedata[15:8];
      end
    end
  end

  assign readdata = readdata_q;
  assign dataHoldCycles = hold_q;
  assign transmitAbortCause = abortCause;
  assign transmitAbortIrq = irq_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstN);

  txlevel_read_a: assert property ((ce && rdLoad && address == TX_LEVEL_ADDR) |=> (readdata == {26'h0, $past(txLevelCount)}))
    else $error("tx level read mismatch");
  rxlevel_read_a: assert property ((ce && rdLoad && address == RX_LEVEL_ADDR) |=> (readdata == {26'h0, $past(rxLevelCount)}))
    else $error("rx level read mismatch");
  hold_write_a: assert property ((wrTake && address == HOLD_ADDR && byteenable == 4'hF) |=> (dataHoldCycles == $past(writedata[15:0])))
    else $error("hold register write lost");
  slvrd_conflict_a: assert property ((ce && slvReadReqActive && txPush && txPushIsRead) |=> abortCause[15])
    else $error("slave read conflict not flagged");
  slvlost_pair_a: assert property ((ce && sclRise && slvTxActive && sdaSync_q[1] != sdaDriveBit) |=> (abortCause[14] && abortCause[12]))
    else $error("slave bus loss pair not set");
  mstlost_flag_a: assert property ((ce && sclRise && mstTxActive && sdaSync_q[1] != sdaDriveBit) |=> abortCause[12])
    else $error("master bus loss not flagged");
  flush_irq_a: assert property ((ce && slvReadCmd && txLevelCount != 6'h00) |=> (abortCause[13] && transmitAbortIrq))
    else $error("stale tx flush abort missing");
  master_dis_a: assert property ((ce && mstStartReq && !masterEnable) |=> abortCause[11])
    else $error("master disabled abort missing");
  tenbit_read_a: assert property ((ce && mstReadCmd && tenBitMode && !repeatedStartAllow) |=> abortCause[10])
    else $error("10-bit read abort missing");
  sbyte_reassert_a: assert property ((ce && abortClear && abortCause[9]) |=> (!abortCause[9] ##1 (!ce || !sbyteCond || abortClear || abortCause[9])))
    else $error("start byte abort clear sequence wrong");
  addr_short_a: assert property ((ce && addrUnacked && !gencallActive && !tenBitMode) |=> abortCause[0])
    else $error("7-bit address nack not flagged");
  clear_all_a: assert property ((ce && abortClear && setVec == 16'h0000) |=> (abortCause == 16'h0000))
    else $error("abort clear did not clear all");
  bus_answer_a: assert property ((busReq && busState_q == BUS_IDLE && ce) |=> (waitrequest == !ce))
    else $error("bus answer not after one wait cycle");
endmodule : iafl_status_regs
`default_nettype wire

// ---- tb/iafl_bus_model.sv ----
// Remote two-wire bus party: clocks one bit and can hold the data line low
`timescale 1ns/1ns
`default_nettype none
module iafl_bus_model (
  input wire logic clk,
  input wire logic go,
  input wire logic pullSda,
  output logic sclLine,
  output logic sdaPull
);
  logic [3:0] cnt_q = 4'h0;
  always_ff @(posedge clk) begin
    if (go) begin
      cnt_q <= 4'h1;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= (cnt_q == 4'hC) ? 4'h0 : cnt_q + 4'h1;
    end
  end
  // Clock line rests high between frames
  assign sclLine = !(cnt_q >= 4'h1 && cnt_q <= 4'h4);
  // Pull spans the rise so the pin synchroniser still sees it
  assign sdaPull = pullSda && cnt_q >= 4'h3 && cnt_q <= 4'hA;
endmodule : iafl_bus_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the abort cause and FIFO level status block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import iafl_pkg::*;
  logic clk, rst_n, ce, read, write, txPush, txPushIsRead, slvReadReqActive, slvReadCmd, slvTxActive;
  logic mstTxActive, mstStartReq, mstPending, masterEnable, repeatedStartAllow, tenBitMode, highSpeedMode;
  logic targetSpecial, gencallOrStartbyteSelect, mstReadCmd, gencallActive, addrUnacked, addrSecondByte;
  logic dataByteUnacked, startByteAcked, sdaDriveBit, abortClear, busGo, busPull, sclLine, sdaPull;
  logic waitrequest, transmitAbortIrq, sdaIn, noMst, noRst;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] writedata, readdata, rd, w;
  logic [BE_W-1:0] byteenable, be;
  logic [LEVEL_W-1:0] txLevelCount, rxLevelCount;
  logic [HOLD_W-1:0] dataHoldCycles, holdExp;
  logic [CAUSE_W-1:0] transmitAbortCause;
  logic [17:0] evIn;
  logic [17:0] stim [15];
  logic [15:0] expc [15];
  int error_cnt, checks;
  assign {txPush, txPushIsRead, slvReadReqActive, slvReadCmd, mstStartReq, mstReadCmd, tenBitMode,
    highSpeedMode, addrUnacked, addrSecondByte, gencallActive, dataByteUnacked, startByteAcked,
    noMst, noRst, mstPending, targetSpecial, gencallOrStartbyteSelect} = evIn;
  assign masterEnable = !noMst;
  assign repeatedStartAllow = !noRst;
  // Open-drain data line with pull-up
  assign sdaIn = sdaDriveBit & !sdaPull;
  iafl_status_regs u_iafl_status_regs (.clk, .rst_n, .ce, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .txLevelCount, .rxLevelCount, .txPush, .txPushIsRead, .slvReadReqActive,
    .slvReadCmd, .slvTxActive, .mstTxActive, .mstStartReq, .mstPending, .masterEnable, .repeatedStartAllow,
    .tenBitMode, .highSpeedMode, .targetSpecial, .gencallOrStartbyteSelect, .mstReadCmd, .gencallActive,
    .addrUnacked, .addrSecondByte, .dataByteUnacked, .startByteAcked, .sdaIn, .sclIn(sclLine), .sdaDriveBit,
    .abortClear, .dataHoldCycles, .transmitAbortCause, .transmitAbortIrq);
  iafl_bus_model u_iafl_bus_model (.clk, .go(busGo), .pullSda(busPull), .sclLine, .sdaPull);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [15:0] holdNext(input logic [15:0] o, input logic [31:0] d, input logic [3:0] e);
    return {e[1] ? d[15:8] : o[15:8], e[0] ? d[7:0] : o[7:0]};
  endfunction : holdNext
  task automatic stop_test;
    $display("Counts: %0d checks, %0d mismatches", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] e);
    int n;
    logic wt;
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= e;
    write <= wr;
    read <= !wr;
    n = 0;
    // Sample between edges so the launch edge of waitrequest cannot race
    do begin
      @(negedge clk);
      n++;
      wt = waitrequest;
      rd = readdata;
    end while (wt !== 1'b0 && n < 40);
    @(posedge clk);
    read <= 1'b0;
    write <= 1'b0;
    if (wt !== 1'b0) begin
      chk("bus timeout", 0, 1);
      stop_test();
    end
  endtask : bus
  task automatic clr;
    @(posedge clk);
    abortClear <= 1'b1;
    @(posedge clk);
    abortClear <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : clr
  initial begin
    {rst_n, read, write, slvTxActive, mstTxActive, abortClear, busGo, busPull} = '0;
    {ce, sdaDriveBit} = 2'h3;
    {address, writedata, byteenable, txLevelCount, rxLevelCount, evIn} = '0;
    stim = '{18'h02010, 18'h38000, 18'h04000, 18'h01808, 18'h02408, 18'h00020, 18'h00040, 18'h00200,
      18'h00A00, 18'h00B00, 18'h00280, 18'h30080, 18'h06010, 18'h30000, 18'h02000};
    expc = '{16'h0800, 16'h8000, 16'h2000, 16'h0400, 16'h0100, 16'h0080, 16'h0008, 16'h0001,
      16'h0002, 16'h0004, 16'h0010, 16'h0020, 16'h2800, 16'h0000, 16'h0000};
    void'($urandom(32'hF44BF0D5));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(0, HOLD_ADDR, 0, 4'hF);
    chk("hold reset", rd, 32'h0000_0001);
    chk("hold out", dataHoldCycles, 16'h0001);
    bus(0, CAUSE_ADDR, 0, 4'hF);
    chk("cause reset", rd, 32'h0000_0000);
    bus(0, TX_LEVEL_ADDR, 0, 4'hF);
    chk("tx level reset", rd, 32'h0000_0000);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      txLevelCount <= (k == 0) ? 6'h3F : LEVEL_W'($urandom);
      rxLevelCount <= (k == 1) ? 6'h3F : LEVEL_W'($urandom);
      bus(0, TX_LEVEL_ADDR, 0, 4'hF);
      chk("tx level", rd, 32'(txLevelCount));
      bus(1, RX_LEVEL_ADDR, 32'hFFFF_FFFF, 4'hF);
      bus(0, RX_LEVEL_ADDR, 0, 4'hF);
      chk("rx level", rd, 32'(rxLevelCount));
    end
    $display("test levels done");
    holdExp = HOLD_RESET;
    for (int k = 0; k < 10; k++) begin
      w = (k == 0) ? 32'hFFFF_FFFF : $urandom;
      be = (k == 0) ? 4'hF : BE_W'($urandom);
      bus(1, HOLD_ADDR, w, be);
      holdExp = holdNext(holdExp, w, be);
      bus(1, 32'h5000_1484, 32'h0000_5A5A, 4'hF);
      bus(0, HOLD_ADDR, 0, 4'hF);
      chk("hold rw", rd, 32'(holdExp));
      chk("hold out", dataHoldCycles, holdExp);
    end
    bus(0, 32'h5000_1484, 0, 4'hF);
    chk("unmapped", rd, 32'h0000_0000);
    bus(1, CAUSE_ADDR, 32'h0000_FFFF, 4'hF);
    bus(0, CAUSE_ADDR, 0, 4'hF);
    chk("cause ro", rd, 32'h0000_0000);
    $display("test hold done");
    txLevelCount <= 6'h01;
    for (int k = 0; k < 15; k++) begin
      @(posedge clk);
      evIn <= stim[k];
      @(posedge clk);
      evIn <= '0;
      repeat (2) @(posedge clk);
      chk("cause", transmitAbortCause, expc[k]);
      chk("irq", transmitAbortIrq, expc[k] != 16'h0);
      bus(0, CAUSE_ADDR, 0, 4'hF);
      chk("cause read", rd, 32'(expc[k]));
      clr();
      chk("cleared", transmitAbortCause, 16'h0000);
    end
    // Clock enable low must swallow an event
    @(posedge clk);
    ce <= 1'b0;
    evIn <= 18'h02010;
    @(posedge clk);
    ce <= 1'b1;
    evIn <= '0;
    repeat (2) @(posedge clk);
    chk("ce freeze", transmitAbortCause, 16'h0000);
    chk("ce freeze irq", transmitAbortIrq, 1'b0);
    $display("test events done");
    @(posedge clk);
    evIn <= 18'h0000F;
    repeat (3) @(posedge clk);
    chk("start byte", transmitAbortCause, 16'h0200);
    abortClear <= 1'b1;
    @(posedge clk);
    abortClear <= 1'b0;
    // Look between edges; the re-arm lands on the very next edge
    @(negedge clk);
    chk("clear drop", transmitAbortCause[9], 1'b0);
    @(negedge clk);
    chk("reassert", transmitAbortCause[9], 1'b1);
    @(posedge clk);
    evIn <= '0;
    clr();
    chk("fixed clear", transmitAbortCause, 16'h0000);
    $display("test restart done");
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      mstTxActive <= (k != 1);
      slvTxActive <= (k == 1);
      busPull <= (k != 2);
      busGo <= 1'b1;
      @(posedge clk);
      busGo <= 1'b0;
      repeat (18) @(posedge clk);
      chk("bus lost", transmitAbortCause, (k == 0) ? 16'h1000 : (k == 1) ? 16'h5000 : 16'h0000);
      clr();
    end
    $display("test bus done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
